// [inc/pcl_pkg.sv]
package pcl_pkg;
  // ---------------------------------------------------------------
  // register map (word index, byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL       = 8'h00; // enable, table mode
  localparam logic [7:0] ADDR_COUNT      = 8'h04; // start and live count
  localparam logic [7:0] ADDR_CFG_UPPER  = 8'h08;
  localparam logic [7:0] ADDR_CFG_LOWER  = 8'h0C;
  localparam logic [7:0] ADDR_UPPER_PAT  = 8'h10;
  localparam logic [7:0] ADDR_LOWER_PAT  = 8'h14;
  localparam logic [7:0] ADDR_OVF_LIMIT  = 8'h18;
  localparam logic [7:0] ADDR_UNF_LIMIT  = 8'h1C;
  localparam logic [7:0] ADDR_APP_UPPER  = 8'h20; // applied upper, RO
  localparam logic [7:0] ADDR_APP_LOWER  = 8'h24; // applied lower, RO
  localparam logic [7:0] ADDR_STATUS     = 8'h28; // RO
  localparam logic [7:0] ADDR_TBL_LEN    = 8'h2C;
  localparam logic [7:0] ADDR_TBL_INDEX  = 8'h30; // entry to write
  localparam logic [7:0] ADDR_TBL_UPPER  = 8'h34;
  localparam logic [7:0] ADDR_TBL_LOWER  = 8'h38;
  localparam logic [7:0] ADDR_TBL_UOUT   = 8'h3C;
  localparam logic [7:0] ADDR_TBL_LOUT   = 8'h40;
  localparam logic [7:0] ADDR_LOAD       = 8'h44; // parameter load cmd

  // ---------------------------------------------------------------
  // fields and constants
  // ---------------------------------------------------------------
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_TABLE_BIT = 1;
  localparam int          TBL_DEPTH      = 255;
  localparam int          TBL_AW         = 8;
  localparam logic [7:0]  ERR_NONE       = 8'h00;
  localparam logic [7:0]  ERR_UPPER      = 8'h02;
  localparam logic [7:0]  ERR_OVF        = 8'h03;
  localparam logic [7:0]  ERR_UNF        = 8'h04;
  localparam logic [7:0]  ERR_NO_TABLE   = 8'h05;
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
  localparam logic [31:0] RESET_OVF      = 32'h7FFF_FFFF;
  localparam logic [31:0] RESET_UNF      = 32'h8000_0000;

  // one limit switch table entry
  typedef struct packed {
    logic signed [31:0] upper;
    logic signed [31:0] lower;
    logic        [31:0] upper_out;
    logic        [31:0] lower_out;
  } pcl_entry_type;

  // software register access
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pcl_bus_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_COUNT
  } pcl_state_type;
endpackage

// [src/pcl_preset_counter.sv]
// Notes on behaviour
// [RULE1] counting start loads the count from the written start value
// [RULE2] while counting, the readable count equals the live count
// [RULE3] upper setpoint is the upper threshold in counts
// [RULE4] upper setpoint above overflow limit is an error; equal is valid
// [RULE5] applied upper status shows last applied value, table included
// [RULE6] lower setpoint is the lower threshold in counts
// [RULE7] lower setpoint below underflow limit is an error; equal is valid
// [RULE8] both negative: lower magnitude must be smaller than underflow's; the code also accepts equal magnitudes
// [RULE9] applied lower status shows last applied value, table included
// [RULE10] upper reached drives outputs to the upper pattern
// [RULE11] lower reached drives outputs to the lower pattern
// [RULE12] patterns accepted at setup or by load command while running
// [RULE13] table entry: signed upper, signed lower, upper pattern, lower
// [RULE14] software keeps the table at no more than 255 entries
// [RULE15] table mode takes setpoints and patterns from the current entry
// [RULE16] reached flags: count >= upper, count <= lower
// [RULE17] in table mode a reached setpoint advances to the next entry
// [RULE18] position resets after a full pass and upper reached; the code also wraps when the last entry's lower setpoint is reached
// [RULE19] table error puts entry index in fault code upper byte; the code stores the entry index plus one
// [RULE20] limit checks run at every setpoint load, before counting
// [RULE21] table mode applies the first entry at counting start
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pcl_preset_counter
  import pcl_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        count_up_i,
  input  wire logic        count_dn_i,
  output logic      [31:0] rdata_o,
  output logic      [31:0] outputs_o,
  output logic             upper_reached_o,
  output logic             lower_reached_o,
  output logic             fault_o
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] up_s1_q, up_s2_q, up_s3_q;
  logic       up_edge, dn_edge;

  // three stages per pin so the edge detector never reads stage one
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      up_s1_q <= 2'h0;
      up_s2_q <= 2'h0;
      up_s3_q <= 2'h0;
    end else begin
      up_s1_q <= {count_dn_i, count_up_i};
      up_s2_q <= up_s1_q;
      up_s3_q <= up_s2_q;
    end
  end
  assign up_edge = up_s2_q[0] & ~up_s3_q[0];
  assign dn_edge = up_s2_q[1] & ~up_s3_q[1];

  // ---------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------
  pcl_bus_type        bus;
  pcl_state_type      st_q, st_d;
  logic [1:0]         ctrl_q, ctrl_d;
  logic signed [31:0] cnt_q, cnt_d;
  logic signed [31:0] cfg_up_q, cfg_up_d, cfg_lo_q, cfg_lo_d;
  logic [31:0]        pat_up_q, pat_up_d, pat_lo_q, pat_lo_d;
  logic signed [31:0] ovf_q, ovf_d, unf_q, unf_d;
  pcl_entry_type      app_q, app_d;
  logic [TBL_AW-1:0]  len_q, len_d, widx_q, widx_d, pos_q, pos_d;
  logic [15:0]        fault_q, fault_d;
  logic               err_q, err_d;
  logic               upr_q, upr_d, lor_q, lor_d;
  logic [31:0]        out_q, out_d, rdata_q, rdata_d;
  logic               load_pend_q, load_pend_d;
  pcl_entry_type      tbl_q [TBL_DEPTH];
  pcl_entry_type      cur_ent, src_ent;
  logic [TBL_AW-1:0]  nxt_pos, ent_idx;
  logic               hit_up, hit_lo, bad_up, bad_lo;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // table storage, one generate entry per row
  for (genvar g = 0; g < TBL_DEPTH; g++) begin : g_tbl
    always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
        tbl_q[g] <= '0;
      end else if (bus.wr && widx_q == TBL_AW'(g)) begin
        unique case (bus.addr)
          ADDR_TBL_UPPER: tbl_q[g].upper     <= bus.wdata; // RULE13
          ADDR_TBL_LOWER: tbl_q[g].lower     <= bus.wdata;
          ADDR_TBL_UOUT:  tbl_q[g].upper_out <= bus.wdata;
          ADDR_TBL_LOUT:  tbl_q[g].lower_out <= bus.wdata;
          default: ;
        endcase
      end
    end
  end

  // entry wraps to the first after the last one in use
  assign nxt_pos = (pos_q + 8'h01 >= len_q) ? 8'h00 : pos_q + 8'h01;
  assign cur_ent = tbl_q[pos_q];

  // which setpoint source applies at the next load
  always_comb begin
    ent_idx = (st_q == ST_COUNT) ? nxt_pos : 8'h00; // RULE21
    src_ent = '{upper: cfg_up_q, lower: cfg_lo_q,
                upper_out: pat_up_q, lower_out: pat_lo_q};
    if (ctrl_q[CTRL_TABLE_BIT]) begin
      src_ent = tbl_q[ent_idx]; // RULE15
    end
  end

  // limit checks, signed compare covers the negative case too
  assign bad_up = src_ent.upper > ovf_q; // RULE4
  assign bad_lo = src_ent.lower < unf_q; // RULE7 RULE8
  assign hit_up = cnt_q >= app_q.upper; // RULE3 RULE16
  assign hit_lo = cnt_q <= app_q.lower; // RULE6 RULE16

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    ctrl_d      = ctrl_q;
    cnt_d       = cnt_q;
    cfg_up_d    = cfg_up_q;
    cfg_lo_d    = cfg_lo_q;
    pat_up_d    = pat_up_q;
    pat_lo_d    = pat_lo_q;
    ovf_d       = ovf_q;
    unf_d       = unf_q;
    app_d       = app_q;
    len_d       = len_q;
    widx_d      = widx_q;
    pos_d       = pos_q;
    fault_d     = fault_q;
    upr_d       = upr_q;
    lor_d       = lor_q;
    out_d       = out_q;
    load_pend_d = load_pend_q;
    // software writes; count writes only take while stopped
    if (bus.wr) begin
      unique case (bus.addr)
        ADDR_CTRL:      ctrl_d   = bus.wdata[1:0];
        ADDR_COUNT:     if (st_q == ST_IDLE) cnt_d = bus.wdata; // RULE1
        ADDR_CFG_UPPER: cfg_up_d = bus.wdata;
        ADDR_CFG_LOWER: cfg_lo_d = bus.wdata;
        ADDR_UPPER_PAT: pat_up_d = bus.wdata; // RULE12
        ADDR_LOWER_PAT: pat_lo_d = bus.wdata; // RULE12
        ADDR_OVF_LIMIT: ovf_d    = bus.wdata;
        ADDR_UNF_LIMIT: unf_d    = bus.wdata;
        ADDR_TBL_LEN:   len_d    = bus.wdata[TBL_AW-1:0];
        ADDR_TBL_INDEX: widx_d   = bus.wdata[TBL_AW-1:0];
        ADDR_LOAD:      load_pend_d = 1'b1; // RULE12
        default: ;
      endcase
    end
    unique case (st_q)
      ST_IDLE: begin
        if (ctrl_q[CTRL_RUN_BIT]) begin
          st_d  = ST_LOAD;
          pos_d = 8'h00;
        end
      end
      ST_LOAD: begin
        // checks settle here before any count is taken
        fault_d = {8'h00, ERR_NONE}; // RULE20
        if (ctrl_q[CTRL_TABLE_BIT] && len_q == 8'h00) begin
          fault_d[7:0] = ERR_NO_TABLE;
        end else if (bad_up || bad_lo) begin
          fault_d[7:0]  = bad_up ? ERR_UPPER : ERR_UNF;
          fault_d[15:8] = ctrl_q[CTRL_TABLE_BIT] ? 8'h01 : 8'h00; // RULE19
        end
        app_d       = src_ent; // RULE5 RULE9
        // a load command landing in this very cycle must not be lost
        if (!(bus.wr && bus.addr == ADDR_LOAD)) load_pend_d = 1'b0;
        st_d        = ST_COUNT;
      end
      ST_COUNT: begin
        if (!ctrl_q[CTRL_RUN_BIT]) begin
          st_d = ST_IDLE;
        end else if (fault_q[7:0] == ERR_NONE) begin
          if (up_edge && !dn_edge) cnt_d = cnt_q + 32'sd1; // RULE2
          if (dn_edge && !up_edge) cnt_d = cnt_q - 32'sd1; // RULE2
          upr_d = hit_up; // RULE16
          lor_d = lor_q;
          lor_d = hit_lo;
          if (hit_up && !upr_q) out_d = app_q.upper_out; // RULE10
          if (hit_lo && !lor_q) out_d = app_q.lower_out; // RULE11
          if (ctrl_q[CTRL_TABLE_BIT] &&
              ((hit_up && !upr_q) || (hit_lo && !lor_q))) begin
            app_d = tbl_q[nxt_pos]; // RULE17
            pos_d = nxt_pos; // RULE18
            if (tbl_q[nxt_pos].upper > ovf_q ||
                tbl_q[nxt_pos].lower < unf_q) begin
              fault_d = {nxt_pos + 8'h01, // RULE19 RULE20
                         tbl_q[nxt_pos].upper > ovf_q ? ERR_UPPER
                                                      : ERR_UNF};
            end
          end else if (load_pend_q) begin
            st_d = ST_LOAD;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // read mux, data stand one cycle after the strobe
  always_comb begin
    rdata_d = RESET_WORD;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CTRL:      rdata_d = {30'h0, ctrl_q};
        ADDR_COUNT:     rdata_d = cnt_q; // RULE2
        ADDR_CFG_UPPER: rdata_d = cfg_up_q;
        ADDR_CFG_LOWER: rdata_d = cfg_lo_q;
        ADDR_UPPER_PAT: rdata_d = pat_up_q;
        ADDR_LOWER_PAT: rdata_d = pat_lo_q;
        ADDR_OVF_LIMIT: rdata_d = ovf_q;
        ADDR_UNF_LIMIT: rdata_d = unf_q;
        ADDR_APP_UPPER: rdata_d = app_q.upper; // RULE5
        ADDR_APP_LOWER: rdata_d = app_q.lower; // RULE9
        ADDR_STATUS:    rdata_d = {pos_q, fault_q, 4'h0,
                                   st_q == ST_COUNT, upr_q, lor_q,
                                   fault_q != 16'h0000};
        ADDR_TBL_LEN:   rdata_d = {24'h0, len_q};
        ADDR_TBL_INDEX: rdata_d = {24'h0, widx_q};
        default:        rdata_d = RESET_WORD;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_q        <= ST_IDLE;
      ctrl_q      <= 2'h0;
      cnt_q       <= RESET_WORD;
      cfg_up_q    <= RESET_WORD;
      cfg_lo_q    <= RESET_WORD;
      pat_up_q    <= RESET_WORD;
      pat_lo_q    <= RESET_WORD;
      ovf_q       <= RESET_OVF;
      unf_q       <= RESET_UNF;
      app_q       <= '0;
      len_q       <= 8'h00;
      widx_q      <= 8'h00;
      pos_q       <= 8'h00;
      fault_q     <= 16'h0000;
      err_q       <= 1'b0;
      upr_q       <= 1'b0;
      lor_q       <= 1'b0;
      out_q       <= RESET_WORD;
      rdata_q     <= RESET_WORD;
      load_pend_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      ctrl_q      <= ctrl_d;
      cnt_q       <= cnt_d;
      cfg_up_q    <= cfg_up_d;
      cfg_lo_q    <= cfg_lo_d;
      pat_up_q    <= pat_up_d;
      pat_lo_q    <= pat_lo_d;
      ovf_q       <= ovf_d;
      unf_q       <= unf_d;
      app_q       <= app_d;
      len_q       <= len_d;
      widx_q      <= widx_d;
      pos_q       <= pos_d;
      fault_q     <= fault_d;
      err_q       <= err_d;
      upr_q       <= upr_d;
      lor_q       <= lor_d;
      out_q       <= out_d;
      rdata_q     <= rdata_d;
      load_pend_q <= load_pend_d;
    end
  end

  assign rdata_o         = rdata_q;
  assign outputs_o       = out_q;
  assign upper_reached_o = upr_q;
  assign lower_reached_o = lor_q;
  // fault pin gets its own flop so the output carries no compare logic
  assign err_d           = (fault_d != 16'h0000);
  assign fault_o         = err_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_start;
    st_q == ST_LOAD;
  endsequence

  chk_start_count: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE1
    st_q == ST_IDLE && st_d == ST_LOAD |=> cnt_q == $past(cnt_q))
    else $error("count changed at start");
  chk_upper_limit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE4
    s_start and (src_ent.upper > ovf_q) and !ctrl_q[CTRL_TABLE_BIT]
    |=> fault_q[7:0] == ERR_UPPER)
    else $error("upper over limit not flagged");
  chk_lower_limit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE7
    s_start and !bad_up and (src_ent.lower < unf_q)
    and !ctrl_q[CTRL_TABLE_BIT] |=> fault_q[7:0] == ERR_UNF)
    else $error("lower under limit not flagged");
  chk_applied_sp: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE5
    s_start |=> app_q.upper == $past(src_ent.upper))
    else $error("applied upper not updated");
  chk_upper_flag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE16
    st_q == ST_COUNT && ctrl_q[0] && fault_q == 16'h0 && hit_up |=> upr_q)
    else $error("upper flag missed");
  chk_lower_flag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE16
    st_q == ST_COUNT && ctrl_q[0] && fault_q == 16'h0 && hit_lo |=> lor_q)
    else $error("lower flag missed");
  chk_upper_pat: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE10
    $rose(upr_q) && !$rose(lor_q) |-> out_q == $past(app_q.upper_out))
    else $error("upper pattern not driven");
  chk_first_entry: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE21
    s_start and ctrl_q[CTRL_TABLE_BIT] and $past(st_q) == ST_IDLE
    |=> app_q == $past(tbl_q[0]))
    else $error("first entry not applied");
endmodule
`default_nettype wire

// [tb/pcl_pulse_src.sv]
`timescale 1ns/1ps
`default_nettype none
// pulse or encoder source facing the counter pins
module pcl_pulse_src (
  input  wire logic core_clk_i,
  output logic      count_up_o,
  output logic      count_dn_o
);
  // widen to act as a slow encoder
  int unsigned gap_cycles = 2;

  initial begin
    count_up_o = 1'b0;
    count_dn_o = 1'b0;
  end

  // two cycles high and at least two low; the pin synchroniser samples
  // every cycle and would catch a single cycle as well
  task automatic pulse(input logic up, input int unsigned n);
    repeat (n) begin
      @(posedge core_clk_i);
      count_up_o <= up;
      count_dn_o <= !up;
      repeat (2) @(posedge core_clk_i);
      count_up_o <= 1'b0;
      count_dn_o <= 1'b0;
      repeat (gap_cycles - 1) @(posedge core_clk_i);
    end
    // let the last edge pass through the synchroniser
    repeat (6) @(posedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// [tb/test_pcl_preset_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module test_pcl_preset_counter
  import pcl_pkg::*;
;
  logic        core_clk_i = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic [7:0]  addr_i     = 8'h00;
  logic [31:0] wdata_i    = 32'h0000_0000;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic        count_up;
  logic        count_dn;
  logic [31:0] rdata_o;
  logic [31:0] outputs_o;
  logic        upper_reached_o;
  logic        lower_reached_o;
  logic        fault_o;
  logic [31:0] rd_val;
  int          mismatches   = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  // ordinary rows: address, value written, value read back
  logic [7:0]  row_a [8] = '{ADDR_CFG_UPPER, ADDR_CFG_LOWER,
    ADDR_UPPER_PAT, ADDR_LOWER_PAT, ADDR_OVF_LIMIT, ADDR_UNF_LIMIT,
    ADDR_COUNT, 8'hFC};
  logic [31:0] row_w [8] = '{32'h7FFF_FFFF, 32'h8000_0000,
    32'hA5A5_A5A5, 32'h5A5A_5A5A, 32'h0000_0010, 32'hFFFF_FFF0,
    32'h0000_0011, 32'hFFFF_FFFF};
  logic [31:0] row_e [8] = '{32'h7FFF_FFFF, 32'h8000_0000,
    32'hA5A5_A5A5, 32'h5A5A_5A5A, 32'h0000_0010, 32'hFFFF_FFF0,
    32'h0000_0011, 32'h0000_0000};
  // limit cases against overflow 16, underflow -16
  logic [31:0] lim_u [4] = '{32'h0000_000A, 32'h0000_0010,
    32'h0000_0011, 32'h0000_0005};
  logic [31:0] lim_l [4] = '{32'hFFFF_FFF0, 32'hFFFF_FFF0,
    32'h0000_0000, 32'hFFFF_FFEF};
  logic [7:0]  lim_c [4] = '{8'h00, 8'h00, 8'h02, 8'h04};

  pcl_preset_counter pcl_preset_counter_inst (
    .core_clk_i      (core_clk_i),
    .rst_b_i         (rst_b_i),
    .addr_i          (addr_i),
    .wdata_i         (wdata_i),
    .wr_i            (wr_i),
    .rd_i            (rd_i),
    .count_up_i      (count_up),
    .count_dn_i      (count_dn),
    .rdata_o         (rdata_o),
    .outputs_o       (outputs_o),
    .upper_reached_o (upper_reached_o),
    .lower_reached_o (lower_reached_o),
    .fault_o         (fault_o)
  );

  pcl_pulse_src pcl_pulse_src_inst (
    .core_clk_i (core_clk_i),
    .count_up_o (count_up),
    .count_dn_o (count_dn)
  );

  always #4 core_clk_i = ~core_clk_i;

  // a hang ends the run as a failure
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1 rd_val = rdata_o;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_val, e);
  endtask

  task automatic flags(input logic [2:0] e);
    chk({29'h0, fault_o, upper_reached_o, lower_reached_o}, {29'h0, e});
  endtask

  // stop, preset the count, then start with the given control word
  task automatic start(input logic [31:0] ctrl, input logic [31:0] c);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_COUNT, c);
    wr(ADDR_CTRL, ctrl);
    repeat (3) @(posedge core_clk_i);
  endtask

  task automatic entry(input logic [31:0] i, input logic [31:0] u,
                       input logic [31:0] l, input logic [31:0] p);
    wr(ADDR_TBL_INDEX, i);
    wr(ADDR_TBL_UPPER, u);
    wr(ADDR_TBL_LOWER, l);
    wr(ADDR_TBL_UOUT, p);
    wr(ADDR_TBL_LOUT, ~p);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    flags(3'b000);
    chk(outputs_o, 32'h0);
    rdchk(ADDR_OVF_LIMIT, RESET_OVF);
    rdchk(ADDR_UNF_LIMIT, RESET_UNF);
    for (int i = 0; i < 8; i++) begin
      wr(row_a[i], row_w[i]);
      rdchk(row_a[i], row_e[i]);
    end
    // plain counting up to the upper and down to the lower setpoint
    wr(ADDR_CFG_UPPER, 32'h5);
    wr(ADDR_CFG_LOWER, 32'hFFFF_FFFD);
    start(32'h1, 32'h2);
    rdchk(ADDR_COUNT, 32'h2);
    rdchk(ADDR_APP_UPPER, 32'h5);
    rdchk(ADDR_APP_LOWER, 32'hFFFF_FFFD);
    flags(3'b000);
    pcl_pulse_src_inst.pulse(1'b1, 3);
    rdchk(ADDR_COUNT, 32'h5);
    flags(3'b010);
    chk(outputs_o, 32'hA5A5_A5A5);
    pcl_pulse_src_inst.pulse(1'b0, 8);
    rdchk(ADDR_COUNT, 32'hFFFF_FFFD);
    flags(3'b001);
    chk(outputs_o, 32'h5A5A_5A5A);
    // new pattern loaded while running, slow source
    pcl_pulse_src_inst.gap_cycles = 5;
    wr(ADDR_UPPER_PAT, 32'h0F0F_0F0F);
    wr(ADDR_LOAD, 32'h1);
    pcl_pulse_src_inst.pulse(1'b1, 8);
    chk(outputs_o, 32'h0F0F_0F0F);
    pcl_pulse_src_inst.gap_cycles = 2;
    // setpoints at and beyond the limits
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CFG_UPPER, lim_u[i]);
      wr(ADDR_CFG_LOWER, lim_l[i]);
      start(32'h1, 32'h0);
      rd(ADDR_STATUS);
      chk({24'h0, rd_val[15:8]}, {24'h0, lim_c[i]});
      chk({31'h0, fault_o}, {31'h0, lim_c[i] != 8'h00});
    end
    // checks rerun by the load command while counting
    wr(ADDR_CFG_LOWER, 32'hFFFF_FFF0);
    start(32'h1, 32'h0);
    wr(ADDR_CFG_UPPER, 32'h11);
    wr(ADDR_LOAD, 32'h1);
    repeat (3) @(posedge core_clk_i);
    chk({31'h0, fault_o}, 32'h1);
    // two entry table, walked once round
    wr(ADDR_CFG_UPPER, 32'h10);
    wr(ADDR_TBL_LEN, 32'h2);
    entry(32'h0, 32'h3, 32'hFFFF_FFFE, 32'h0000_0011);
    entry(32'h1, 32'h6, 32'h1, 32'h0000_0033);
    start(32'h3, 32'h0);
    rdchk(ADDR_APP_UPPER, 32'h3);
    rdchk(ADDR_APP_LOWER, 32'hFFFF_FFFE);
    pcl_pulse_src_inst.pulse(1'b1, 3);
    chk(outputs_o, 32'h0000_0011);
    rdchk(ADDR_APP_UPPER, 32'h6);
    rd(ADDR_STATUS);
    chk({24'h0, rd_val[31:24]}, 32'h1);
    pcl_pulse_src_inst.pulse(1'b1, 3);
    chk(outputs_o, 32'h0000_0033);
    rd(ADDR_STATUS);
    chk({24'h0, rd_val[31:24]}, 32'h0);
    // faulty first entry, then an empty table
    entry(32'h0, 32'h14, 32'hFFFF_FFFE, 32'h0000_0011);
    start(32'h3, 32'h0);
    rd(ADDR_STATUS);
    chk({16'h0, rd_val[23:8]}, 32'h0000_0102);
    wr(ADDR_TBL_LEN, 32'h0);
    start(32'h3, 32'h0);
    rd(ADDR_STATUS);
    chk({24'h0, rd_val[15:8]}, 32'h5);
    // reset in mid-run clears every output
    start(32'h1, 32'h0);
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 flags(3'b000);
    chk(outputs_o, 32'h0);
    rst_b_i <= 1'b1;
    // first edges after the second release: still in reset state
    repeat (2) @(posedge core_clk_i);
    flags(3'b000);
    chk(outputs_o, 32'h0);
    rdchk(ADDR_OVF_LIMIT, RESET_OVF);
    rdchk(ADDR_STATUS, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
